// *** ilcgd_defs.vh ***
/*
 * Constants of the in-band loop code generator and detectors: register
 * offsets, field positions, reset values and the integration length.
 * Assumes a byte-wide register port with an 8-bit address.
 */
`ifndef ILCGD_DEFS_VH
`define ILCGD_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ILCGD_OFS_INBAND_CTRL   8'hB6
`define ILCGD_OFS_TX_FIRST      8'hB7
`define ILCGD_OFS_TX_LOW        8'hB8
`define ILCGD_OFS_UP_FIRST      8'hB9
`define ILCGD_OFS_UP_LOW        8'hBA
`define ILCGD_OFS_DOWN_FIRST    8'hBB
`define ILCGD_OFS_DOWN_LOW      8'hBC
`define ILCGD_OFS_SPARE_CTRL    8'hBD
`define ILCGD_OFS_SPARE_FIRST   8'hBE
`define ILCGD_OFS_SPARE_LOW     8'hBF
`define ILCGD_OFS_RX_LINK       8'hC0
`define ILCGD_OFS_IRQ_STATUS    8'hE0
`define ILCGD_OFS_IRQ_MASK      8'hE1
`define ILCGD_OFS_MODE_CTRL     8'hE2
`define ILCGD_OFS_DETECT_STATE  8'hE3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ILCGD_TX_LEN_HI         7
`define ILCGD_TX_LEN_LO         6
`define ILCGD_UP_LEN_HI         5
`define ILCGD_UP_LEN_LO         3
`define ILCGD_DOWN_LEN_HI       2
`define ILCGD_DOWN_LEN_LO       0
`define ILCGD_SPARE_LEN_HI      2
`define ILCGD_SPARE_LEN_LO      0
`define ILCGD_MODE_TX_EN        0
`define ILCGD_MODE_BOC          4
`define ILCGD_EVT_LINK_BYTE     3
`define ILCGD_EVT_BOC           4
`define ILCGD_EVT_W             5

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define ILCGD_RST_BYTE          8'h00
`define ILCGD_LEN_LONG_SEL      3'h7
`define ILCGD_LEN_LONG          5'h10
`define ILCGD_INTEG_BITS        16'h0400

`endif

// *** ilcgd_top.v ***
/*
 * In-band loop code block: one repeating-code transmit generator, three
 * receive detectors (up, down, spare), the receive facility link register
 * with its bit-oriented-code view, and a sticky interrupt status.
 * Assumes line bits arrive as one-cycle enables synchronous to clk and
 * a host that issues one-cycle read or write strobes.
 */
`include "ilcgd_defs.vh"

// Function
// - down length field 000..110 gives 1..7 bits, 111 gives the 8/16 length
// - bit 7 of first transmit pattern is sent first each repetition
// - transmit ignores bit 2 at 5, bit 1 at 5/6, bit 0 at 5/6/7
// - second transmit register is the low byte of 16 bits, unused at 5..7
// - transmit length 00=5, 01=6/3, 10=7, 11=16/8/4/2/1 bits
// - writing a detector first pattern register restarts its integration
// - detector compares only top N bits of first pattern, bit 7 first
// - detector ignores second pattern register for lengths 1..7
// - up length field sits in bits 3..5, same coding as down field
// - spare length field in bits 0..2, 1..7 bits or the 8/16 length
// - with code mode set, link register shows six-bit code in bits 0..5
// - with code mode clear, link register shows link byte, first bit in LSB
// - all pattern registers and spare control reset to zero
module ilcgd_top (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData_q,
  input  wire       txBitEn,
  output reg        txCodeBit_q,
  input  wire       rxBitEn,
  input  wire       rxBit,
  input  wire       linkBitEn,
  input  wire       linkBit,
  input  wire       bocValid,
  input  wire [5:0] bocCode,
  output wire       upDetect_q,
  output wire       downDetect_q,
  output wire       spareDetect_q,
  output reg        irq_q
);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  reg [7:0] inbandCtrl_q;
  reg [7:0] txFirst_q;
  reg [7:0] txLow_q;
  reg [7:0] upFirst_q;
  reg [7:0] upLow_q;
  reg [7:0] downFirst_q;
  reg [7:0] downLow_q;
  reg [7:0] spareCtrl_q;
  reg [7:0] spareFirst_q;
  reg [7:0] spareLow_q;
  reg [7:0] modeCtrl_q;
  reg [`ILCGD_EVT_W-1:0] irqMask_q;

  // status is cleared in the interrupt section, never from here

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inbandCtrl_q <= `ILCGD_RST_BYTE;
      txFirst_q    <= `ILCGD_RST_BYTE;
      txLow_q      <= `ILCGD_RST_BYTE;
      upFirst_q    <= `ILCGD_RST_BYTE;
      upLow_q      <= `ILCGD_RST_BYTE;
      downFirst_q  <= `ILCGD_RST_BYTE;
      downLow_q    <= `ILCGD_RST_BYTE;
      spareCtrl_q  <= `ILCGD_RST_BYTE;
      spareFirst_q <= `ILCGD_RST_BYTE;
      spareLow_q   <= `ILCGD_RST_BYTE;
      modeCtrl_q   <= `ILCGD_RST_BYTE;
      irqMask_q    <= {`ILCGD_EVT_W{1'b0}};
    end else if (regWr) begin
      case (regAddr)
        `ILCGD_OFS_INBAND_CTRL:  inbandCtrl_q <= regWrData;
        `ILCGD_OFS_TX_FIRST:     txFirst_q    <= regWrData;
        `ILCGD_OFS_TX_LOW:       txLow_q      <= regWrData;
        `ILCGD_OFS_UP_FIRST:     upFirst_q    <= regWrData;
        `ILCGD_OFS_UP_LOW:       upLow_q      <= regWrData;
        `ILCGD_OFS_DOWN_FIRST:   downFirst_q  <= regWrData;
        `ILCGD_OFS_DOWN_LOW:     downLow_q    <= regWrData;
        // upper bits kept as written; only the low field steers anything
        `ILCGD_OFS_SPARE_CTRL:   spareCtrl_q  <= regWrData;
        `ILCGD_OFS_SPARE_FIRST:  spareFirst_q <= regWrData;
        `ILCGD_OFS_SPARE_LOW:    spareLow_q   <= regWrData;
        `ILCGD_OFS_MODE_CTRL:    modeCtrl_q   <= regWrData;
        `ILCGD_OFS_IRQ_MASK:     irqMask_q    <= regWrData[`ILCGD_EVT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // transmit code generator
  // ----------------------------------------------------------------------
  reg  [4:0]  txLen;
  reg  [4:0]  txPhase_q;
  reg  [15:0] txPattern;
  wire        txEnable  = modeCtrl_q[`ILCGD_MODE_TX_EN];

  // 3, 8, 4, 2 and 1 bit codes are sent as their 6 or 16 bit repeats
  always @* begin
    case (inbandCtrl_q[`ILCGD_TX_LEN_HI:`ILCGD_TX_LEN_LO])
      2'h0:    txLen = 5'h05;
      2'h1:    txLen = 5'h06;
      2'h2:    txLen = 5'h07;
      default: txLen = `ILCGD_LEN_LONG;
    endcase
  end

  // ----------------------------------------------------------------------
  // transmit pattern select
  // ----------------------------------------------------------------------
  // don't-care bits forced low so a stray write there never reaches the line
  always @* begin
    case (inbandCtrl_q[`ILCGD_TX_LEN_HI:`ILCGD_TX_LEN_LO])
      2'h0:    txPattern = {txFirst_q[7:3], 11'h000};
      2'h1:    txPattern = {txFirst_q[7:2], 10'h000};
      2'h2:    txPattern = {txFirst_q[7:1], 9'h000};
      default: txPattern = {txFirst_q, txLow_q};
    endcase
  end

  // ----------------------------------------------------------------------
  // transmit bit sequencer
  // ----------------------------------------------------------------------

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txPhase_q   <= 5'h00;
      txCodeBit_q <= 1'b0;
    end else if (!txEnable) begin
      txPhase_q   <= 5'h00;
      txCodeBit_q <= 1'b0;
    end else if (txBitEn) begin
      // phase 0 reads bit 15, i.e. first-register bit 7; at 5..7 bits the
      // phase never reaches the low bits or the second register
      txCodeBit_q <= txPattern[4'hF - txPhase_q[3:0]];
      if (txPhase_q >= txLen - 5'h01) begin
        txPhase_q <= 5'h00;
      end else begin
        txPhase_q <= txPhase_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive detectors
  // ----------------------------------------------------------------------
  reg  [15:0] rxHist_q;
  wire [7:0]  detFirst  [0:2];
  wire [7:0]  detLow    [0:2];
  wire [2:0]  detSel    [0:2];
  wire [7:0]  detFirstOfs [0:2];
  wire [2:0]  detVec;

  assign detFirst[0] = upFirst_q;
  assign detFirst[1] = downFirst_q;
  assign detFirst[2] = spareFirst_q;
  assign detLow[0]   = upLow_q;
  assign detLow[1]   = downLow_q;
  assign detLow[2]   = spareLow_q;
  assign detSel[0]   = inbandCtrl_q[`ILCGD_UP_LEN_HI:`ILCGD_UP_LEN_LO];
  assign detSel[1]   = inbandCtrl_q[`ILCGD_DOWN_LEN_HI:`ILCGD_DOWN_LEN_LO];
  assign detSel[2]   = spareCtrl_q[`ILCGD_SPARE_LEN_HI:`ILCGD_SPARE_LEN_LO];
  assign detFirstOfs[0] = `ILCGD_OFS_UP_FIRST;
  assign detFirstOfs[1] = `ILCGD_OFS_DOWN_FIRST;
  assign detFirstOfs[2] = `ILCGD_OFS_SPARE_FIRST;

  // ----------------------------------------------------------------------
  // receive line history
  // ----------------------------------------------------------------------
  // newest bit in bit 0, so the last N bits read oldest-first from N-1 down
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxHist_q <= 16'h0000;
    end else if (rxBitEn) begin
      rxHist_q <= {rxHist_q[14:0], rxBit};
    end
  end

  // ----------------------------------------------------------------------
  // code detectors
  // ----------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : gDet
      reg  [4:0]  len;
      wire [15:0] pattern;
      wire [15:0] mask;
      wire [15:0] aligned;
      wire        match;
      wire        restart;
      reg  [4:0]  since_q;
      reg  [15:0] run_q;
      reg         det_q;

      // 111 is taken as 16 bits; an 8-bit code is written into both bytes
      always @* begin
        case (detSel[k])
          3'h0:                len = 5'h01;
          3'h1:                len = 5'h02;
          3'h2:                len = 5'h03;
          3'h3:                len = 5'h04;
          3'h4:                len = 5'h05;
          3'h5:                len = 5'h06;
          3'h6:                len = 5'h07;
          `ILCGD_LEN_LONG_SEL: len = `ILCGD_LEN_LONG;
          default:             len = 5'h01;
        endcase
      end
      // low byte joins only for the long length
      assign pattern = (len == `ILCGD_LEN_LONG) ? {detFirst[k], detLow[k]} :
                       {detFirst[k], 8'h00};
      assign mask    = 16'hFFFF << (5'h10 - len);
      assign aligned = rxHist_q << (5'h10 - len);
      assign match   = ((aligned ^ pattern) & mask) == 16'h0000;
      assign restart = regWr && (regAddr == detFirstOfs[k]);

      // a match at most N bits after the previous one keeps the run alive;
      // shorter gaps are rotations of a self-similar code and also count;
      // a restart wins over a line bit landing in the same cycle
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          since_q <= 5'h00;
          run_q   <= 16'h0000;
          det_q   <= 1'b0;
        end else if (restart) begin
          since_q <= 5'h00;
          run_q   <= 16'h0000;
          det_q   <= 1'b0;
        end else if (rxBitEn) begin
          // saturate: a wrap would reopen a window in which misses go unseen
          if (match) begin
            since_q <= 5'h00;
          end else if (since_q != 5'h1F) begin
            since_q <= since_q + 5'h01;
          end
          if (!match && since_q >= len - 5'h01) begin
            run_q <= 16'h0000;
            det_q <= 1'b0;
          end else if (run_q < `ILCGD_INTEG_BITS) begin
            run_q <= run_q + 16'h0001;
          end else begin
            det_q <= 1'b1;
          end
        end
      end

      assign detVec[k] = det_q;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // detector outputs
  // ----------------------------------------------------------------------
  assign upDetect_q    = detVec[0];
  assign downDetect_q  = detVec[1];
  assign spareDetect_q = detVec[2];

  // ----------------------------------------------------------------------
  // receive facility link
  // ----------------------------------------------------------------------
  reg  [7:0] linkShift_q;
  reg  [2:0] linkCnt_q;
  reg  [7:0] linkByte_q;
  reg  [5:0] boc_q;
  reg        linkDone;
  wire       bocMode = modeCtrl_q[`ILCGD_MODE_BOC];

  // the eighth bit completes a byte; the counter wraps by itself
  always @* begin
    linkDone = linkBitEn && (linkCnt_q == 3'h7);
  end

  // shift right so the first bit received ends up in bit 0
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      linkShift_q <= 8'h00;
      linkCnt_q   <= 3'h0;
      linkByte_q  <= 8'h00;
      boc_q       <= 6'h00;
    end else begin
      if (linkBitEn) begin
        linkShift_q <= {linkBit, linkShift_q[7:1]};
        linkCnt_q   <= linkCnt_q + 3'h1;
      end
      if (linkDone) begin
        linkByte_q <= {linkBit, linkShift_q[7:1]};
      end
      // a code arrives whole from the framer, so nothing is shifted here
      if (bocValid) begin
        boc_q <= bocCode;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  reg  [2:0]              detPrev_q;
  reg  [`ILCGD_EVT_W-1:0] irqStatus_q;
  wire [`ILCGD_EVT_W-1:0] evtSet;
  wire [`ILCGD_EVT_W-1:0] evtClr;
  reg  [`ILCGD_EVT_W-1:0] irqStatus_d;

  assign evtSet = {bocValid && bocMode, linkDone && !bocMode, detVec & ~detPrev_q};
  assign evtClr = (regWr && regAddr == `ILCGD_OFS_IRQ_STATUS) ?
                  regWrData[`ILCGD_EVT_W-1:0] : {`ILCGD_EVT_W{1'b0}};

  always @* begin
    irqStatus_d = (irqStatus_q & ~evtClr) | evtSet;
  end

  // a new event beats a clear landing in the same cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      detPrev_q   <= 3'h0;
      irqStatus_q <= {`ILCGD_EVT_W{1'b0}};
      irq_q       <= 1'b0;
    end else begin
      detPrev_q   <= detVec;
      irqStatus_q <= irqStatus_d;
      // irq follows the next status value so it rises with the flag itself
      irq_q       <= |(irqStatus_d & irqMask_q);
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  reg [7:0] rdMux;

  // unmapped addresses read as zero; E3 lets software poll the detectors
  always @* begin
    case (regAddr)
      `ILCGD_OFS_INBAND_CTRL:  rdMux = inbandCtrl_q;
      `ILCGD_OFS_TX_FIRST:     rdMux = txFirst_q;
      `ILCGD_OFS_TX_LOW:       rdMux = txLow_q;
      `ILCGD_OFS_UP_FIRST:     rdMux = upFirst_q;
      `ILCGD_OFS_UP_LOW:       rdMux = upLow_q;
      `ILCGD_OFS_DOWN_FIRST:   rdMux = downFirst_q;
      `ILCGD_OFS_DOWN_LOW:     rdMux = downLow_q;
      `ILCGD_OFS_SPARE_CTRL:   rdMux = spareCtrl_q;
      `ILCGD_OFS_SPARE_FIRST:  rdMux = spareFirst_q;
      `ILCGD_OFS_SPARE_LOW:    rdMux = spareLow_q;
      `ILCGD_OFS_RX_LINK:      rdMux = bocMode ? {2'b00, boc_q} : linkByte_q;
      `ILCGD_OFS_IRQ_STATUS:   rdMux = {3'h0, irqStatus_q};
      `ILCGD_OFS_IRQ_MASK:     rdMux = {3'h0, irqMask_q};
      `ILCGD_OFS_MODE_CTRL:    rdMux = modeCtrl_q;
      `ILCGD_OFS_DETECT_STATE: rdMux = {5'h00, detVec};
      default:                 rdMux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData_q <= 8'h00;
    end else if (regRd) begin
      regRdData_q <= rdMux;
    end else begin
      regRdData_q <= 8'h00;
    end
  end

endmodule

// *** ilcgd_props.sv ***
/*
 * Port checker for the in-band loop code block.
 * Assumes one clock, async active-low reset and the top port names.
 */
module ilcgd_props (
  input logic       clk,
  input logic       rstn,
  input logic [7:0] regAddr,
  input logic       regWr,
  input logic       regRd,
  input logic [7:0] regRdData_q,
  input logic       txBitEn,
  input logic       txCodeBit_q,
  input logic       rxBitEn,
  input logic       upDetect_q,
  input logic       downDetect_q,
  input logic       spareDetect_q,
  input logic       irq_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // bits seen since the last up restart
  // ----------------------------------------
  logic [10:0] rxCnt_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) rxCnt_q <= 11'h000;
    else if (regWr && regAddr == 8'hB9) rxCnt_q <= 11'h000;
    else if (rxBitEn && rxCnt_q != 11'h7FF) rxCnt_q <= rxCnt_q + 11'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rd_only_after: assert property (regRdData_q != 8'h00 |-> $past(regRd))
    else $error("read data outside read slot");
  a_rd_unmapped: assert property (regRd && regAddr == 8'h00 |=> regRdData_q == 8'h00)
    else $error("unmapped read not zero");
  a_tx_hold_bit: assert property (!txBitEn && !$past(regWr) |=> $stable(txCodeBit_q))
    else $error("tx bit moved without enable");
  a_up_rise_bit: assert property ($rose(upDetect_q) |-> $past(rxBitEn))
    else $error("up detect rose off a bit time");
  a_up_full_integ: assert property ($rose(upDetect_q) |-> rxCnt_q >= 11'h400)
    else $error("up detect before integration");
  a_up_restart: assert property (regWr && regAddr == 8'hB9 |=> !upDetect_q)
    else $error("up detect kept after write");
  a_down_restart: assert property (regWr && regAddr == 8'hBB |=> !downDetect_q)
    else $error("down detect kept after write");
  a_spare_restart: assert property (regWr && regAddr == 8'hBE |=> !spareDetect_q)
    else $error("spare detect kept after write");
  a_down_fall_cause: assert property ($fell(downDetect_q) |-> $past(rxBitEn || regWr))
    else $error("down detect fell without cause");
  c_up: cover property ($rose(upDetect_q));
  c_down: cover property ($rose(downDetect_q));
  c_spare: cover property ($rose(spareDetect_q));
  c_irq: cover property ($rose(irq_q));
endmodule

bind ilcgd_top ilcgd_props props_u (.clk, .rstn, .regAddr, .regWr, .regRd, .regRdData_q,
  .txBitEn, .txCodeBit_q, .rxBitEn, .upDetect_q, .downDetect_q, .spareDetect_q, .irq_q);

// *** ilcgd_line_model.sv ***
/*
 * Far-end line equipment: repeats a code of len bits, bit 15 first.
 * Assumes the bench sets pat and len; idle line carries zeros.
 */
module ilcgd_line_model (
  input  logic        clk,
  input  logic        rstn,
  input  logic        run,
  input  logic        slow,
  input  logic [15:0] pat,
  input  logic [4:0]  len,
  output logic        lineEn_q,
  output logic        lineBit_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] idx_q;
  logic       tog_q;
  // slow mode gives a bit every other cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= 5'h00;
      tog_q <= 1'b0;
      lineEn_q <= 1'b0;
      lineBit_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      lineEn_q <= ~slow | tog_q;
      if (~slow | tog_q) begin
        lineBit_q <= run & pat[5'h0F - idx_q];
        idx_q <= (idx_q >= len - 5'h01) ? 5'h00 : idx_q + 5'h01;
      end
    end
  end
endmodule

// *** ilcgd_top_tb.sv ***
/*
 * Self-checking bench for the in-band loop code block.
 * Assumes the line model drives the receive bit stream.
 */
module ilcgd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rstn, regWr, regRd, txBitEn, linkBitEn, linkBit, bocValid;
  logic       run, slow;
  logic [7:0] regAddr, regWrData, rdv;
  logic [5:0] bocCode;
  logic [15:0] pat;
  logic [4:0] plen;
  wire  [7:0] regRdData_q;
  wire        txCodeBit_q, rxBitEn, rxBit, upDetect_q, downDetect_q, spareDetect_q, irq_q;
  wire  [2:0] det = {spareDetect_q, downDetect_q, upDetect_q};
  int         n_errors, checks;

  ilcgd_top dut_u (.clk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q,
    .txBitEn, .txCodeBit_q, .rxBitEn, .rxBit, .linkBitEn, .linkBit, .bocValid,
    .bocCode, .upDetect_q, .downDetect_q, .spareDetect_q, .irq_q);
  ilcgd_line_model line_u (.clk, .rstn, .run, .slow, .pat, .len(plen),
    .lineEn_q(rxBitEn), .lineBit_q(rxBit));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin regAddr <= a; regWrData <= d; regWr <= 1'b1; end
    @(posedge clk) regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge clk) regRd <= 1'b0;
    #1 d = regRdData_q;
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    for (int a = 8'hB7; a <= 8'hC0; a++) begin
      rd(a[7:0], rdv);
      chk("reset value", 8'h00, rdv);
    end
    wr(8'hC0, 8'hFF);
    rd(8'hC0, rdv);
    chk("read-only link", 8'h00, rdv);
    rd(8'h00, rdv);
    chk("unmapped", 8'h00, rdv);
  endtask
  task t_tx;
    logic [15:0] w;
    int n;
    w = 16'hAF5A;
    for (int tc = 0; tc < 4; tc++) begin
      n = (tc == 3) ? 16 : 5 + tc;
      wr(8'hE2, 8'h00);
      wr(8'hB6, {tc[1:0], 6'h00});
      wr(8'hB7, w[15:8]);
      wr(8'hB8, w[7:0]);
      wr(8'hE2, 8'h01);
      for (int i = 0; i < 2 * n; i++) begin
        @(posedge clk) txBitEn <= 1'b1;
        @(posedge clk) txBitEn <= 1'b0;
        #1 chk("tx bit", {7'h00, w[15 - (i % n)]}, {7'h00, txCodeBit_q});
      end
    end
  endtask
  task t_link;
    logic [7:0] b;
    b = 8'hB4;
    wr(8'hE2, 8'h00);
    wr(8'hE1, 8'h00);
    wr(8'hE0, 8'hFF);
    for (int i = 0; i < 8; i++) @(posedge clk) begin linkBitEn <= 1'b1; linkBit <= b[i]; end
    @(posedge clk) linkBitEn <= 1'b0;
    rd(8'hC0, rdv);
    chk("link byte", b, rdv);
    repeat (2) @(posedge clk);
    chk("irq masked", 8'h00, {7'h00, irq_q});
    wr(8'hE1, 8'h08);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 8'h01, {7'h00, irq_q});
    wr(8'hE2, 8'h10);
    @(posedge clk) begin bocValid <= 1'b1; bocCode <= 6'h2D; end
    @(posedge clk) bocValid <= 1'b0;
    rd(8'hC0, rdv);
    chk("code view", 8'h2D, rdv);
  endtask
  task t_det;
    logic [7:0] f, lo, fa, m;
    int n, k;
    for (int d = 0; d < 3; d++) for (int s = 0; s < 8; s++) begin
      n = (s == 7) ? 16 : s + 1;
      // junk below the top bits must not matter
      f = (s == 7) ? 8'h80 : 8'h80 | (8'hFF >> n);
      lo = (s == 7) ? 8'h01 : 8'hFF;
      fa = (d == 0) ? 8'hB9 : (d == 1) ? 8'hBB : 8'hBE;
      m = 8'h01 << d;
      if (d == 2) wr(8'hBD, {5'h00, s[2:0]});
      else wr(8'hB6, (d == 0) ? {2'b00, s[2:0], 3'b000} : {5'h00, s[2:0]});
      wr(fa, f);
      wr(fa + 8'h01, lo);
      wr(8'hE1, m);
      wr(8'hE0, 8'hFF);
      pat <= {f, lo};
      plen <= n[4:0];
      slow <= (d == 1);
      run <= 1'b1;
      k = 0;
      while (det[d] !== 1'b1 && k < 3000) begin @(posedge clk); k++; end
      chk("detect", 8'h01, {7'h00, det[d]});
      repeat (2) @(posedge clk);
      chk("irq set", 8'h01, {7'h00, irq_q});
      rd(8'hE0, rdv);
      chk("status", m, rdv & m);
      rd(8'hE3, rdv);
      chk("detect state", m, rdv & m);
      wr(8'hE0, m);
      repeat (2) @(posedge clk);
      chk("irq cleared", 8'h00, {7'h00, irq_q});
      if (s[0]) begin
        wr(fa, f);
        #1 chk("restart", 8'h00, {7'h00, det[d]});
        repeat (100) @(posedge clk);
        chk("still integrating", 8'h00, {7'h00, det[d]});
      end
      run <= 1'b0;
      k = 0;
      while (det[d] !== 1'b0 && k < 80) begin @(posedge clk); k++; end
      chk("drop", 8'h00, {7'h00, det[d]});
    end
  endtask

  initial begin
    #2400000;
    n_errors++;
    final_report;
  end
  initial begin
    rstn = 1'b0;
    {regWr, regRd, txBitEn, linkBitEn, linkBit, bocValid, run, slow} = 8'h00;
    regAddr = 8'h00;
    regWrData = 8'h00;
    bocCode = 6'h00;
    pat = 16'h0000;
    plen = 5'h01;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_tx;
    t_link;
    t_det;
    final_report;
  end
endmodule
